//--- pps_host.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// fieldbus host model, classic wishbone master
// ****************************************
module pps_host
(
	// clock
	input  wire logic        ref_clk,
	// wishbone master
	output logic             wb_cyc_o,
	output logic             wb_stb_o,
	output logic             wb_we_o,
	output logic      [7:0]  wb_adr_o,
	output logic      [3:0]  wb_sel_o,
	output logic      [31:0] wb_dat_o,
	input  wire logic [31:0] wb_dat_i,
	input  wire logic        wb_ack_i
);
	int timeouts;
	initial
	begin
		timeouts = 0;
		wb_cyc_o = 1'b0;
		wb_stb_o = 1'b0;
		wb_we_o = 1'b0;
		wb_adr_o = 8'hFF;
		wb_sel_o = 4'h0;
		wb_dat_o = 32'h0;
	end
	// entered just after a rising edge; request held until ack is sampled or 64 cycles pass without it
	task automatic xfer(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		int n;
		n = 0;
		wb_cyc_o <= 1'b1;
		wb_stb_o <= 1'b1;
		wb_we_o <= we;
		wb_adr_o <= a;
		wb_sel_o <= 4'hF;
		wb_dat_o <= d;
		@(posedge ref_clk);
		while (wb_ack_i !== 1'b1 && n < 64)
		begin
			n++;
			@(posedge ref_clk);
		end
		if (n >= 64)
			timeouts++;
		q = wb_dat_i;
		wb_cyc_o <= 1'b0;
		wb_stb_o <= 1'b0;
		wb_we_o <= 1'b0;
		// released lines toggle so a stale value cannot pass for a live one
		wb_adr_o <= ~a;
		wb_dat_o <= ~d;
		@(posedge ref_clk);
	endtask
endmodule
`default_nettype wire

//--- pps_params.svh
`ifndef PPS_PARAMS_SVH
`define PPS_PARAMS_SVH
// register byte offsets
`define PPS_OFF_CTRL      8'h00
`define PPS_OFF_MODE      8'h04
`define PPS_OFF_TARGET    8'h08
`define PPS_OFF_OPTS      8'h0C
`define PPS_OFF_LIMLO     8'h10
`define PPS_OFF_LIMHI     8'h14
`define PPS_OFF_WIN       8'h18
`define PPS_OFF_DWELL     8'h1C
`define PPS_OFF_FEWIN     8'h20
`define PPS_OFF_FETMO     8'h24
`define PPS_OFF_PROF      8'h28
`define PPS_OFF_STATUS    8'h2C
`define PPS_OFF_ACTPOS    8'h30
`define PPS_OFF_DEMPOS    8'h34
`define PPS_OFF_ACTIVE    8'h38
`define PPS_OFF_PEND      8'h3C
`define PPS_OFF_DRIVE     8'h40
// control word bits
`define PPS_CW_START      4
`define PPS_CW_IMMED      5
`define PPS_CW_REL        6
`define PPS_CW_HALT       8
`define PPS_CW_PASS       9
// status word bits
`define PPS_SW_REACHED    10
`define PPS_SW_LIMIT      11
`define PPS_SW_ACK        12
`define PPS_SW_FOLERR     13
// option code fields
`define PPS_OPT_REF_LSB   0
`define PPS_OPT_CLR_LSB   4
// drive input word bits
`define PPS_DRV_ATSPEED   0
`define PPS_DRV_CLOSED    1
`define PPS_DRV_SWINLIM   2
// values
`define PPS_MODE_PP       8'h01
`define PPS_PROF_JERK     8'h03
`define PPS_RST_LIMLO     32'h80000000
`define PPS_RST_LIMHI     32'h7FFFFFFF
`define PPS_RST_WIN       32'h0000000A
`define PPS_RST_DWELL     16'h0000
`define PPS_RST_FEWIN     32'h00000100
`define PPS_RST_FETMO     16'h000A
// timing
`define PPS_CLK_MHZ       200
`define PPS_CYCLE_US      1000
`define PPS_CYCLE_CLKS    (`PPS_CYCLE_US * `PPS_CLK_MHZ)
`endif

//--- pps_pkg.sv
package pps_pkg;
	typedef enum logic [2:0]
	{
		PPS_IDLE = 3'b001,
		PPS_MOVE = 3'b010,
		PPS_HALT = 3'b100
	} pps_state_t;
	typedef struct packed
	{
		pps_state_t  st;
		logic [17:0] tick_cnt;
		logic [15:0] ctrl;
		logic [7:0]  mode;
		logic [31:0] target;
		logic [7:0]  opts;
		logic [31:0] lim_lo;
		logic [31:0] lim_hi;
		logic [31:0] win;
		logic [15:0] dwell;
		logic [31:0] fe_win;
		logic [15:0] fe_tmo;
		logic [7:0]  prof;
		logic [15:0] ctrl_prev;
		logic        mode_prev;
		logic        ack;
		logic        reached;
		logic        limit;
		logic        folerr;
		logic [15:0] dwell_cnt;
		logic [15:0] fe_cnt;
		logic [31:0] act_goal;
		logic        act_pass;
		logic        pend_vld;
		logic [31:0] pend_goal;
		logic        pend_pass;
		logic [31:0] prev_goal;
		logic [31:0] act_smp;
		logic        ack_o;
		logic [31:0] rdat;
	} pps_regs_t;
endpackage

//--- pps_seq.sv
// Overview of operation
// - a travel command starts only on a rising start bit.
// - immediate bit applies new command at once, else after current move.
// - relative bit adds goal to reference chosen by option bits 0..1.
// - halt bit holds motor stopped; braking and restart ramps outside.
// - pass-through keeps speed, no braking before the first goal.
// - immediate overrides; else complete first, or pass through with bit 9.
// - pass-through ignored when ramp speed is not reached at goal; code checks at_speed when the goal is buffered, not at arrival.
// - goal-reached only after last goal and dwell inside window.
// - limit bit shows demand position outside software limits.
// - acknowledge follows start bit handshake.
// - queued command acknowledge clears when taken; commands during ack dropped.
// - no acknowledge for unreachable goal or already full buffer.
// - following-error bit after error over window past timeout.
// - host writes goal then start; device acks, moves, reports arrival.
// - option bits 4..5 let device clear the start bit itself.
// - ack drops when one more goal can be buffered; one goal queued.
// - full buffer ignores new goal; immediate bypasses buffer.
// - pass-through holds speed until goal, then next limits apply.
// - option value 0 references relative move to preceding goal.
// - actual position sampled each ms; sample is base after nonzero end speed; code uses it for any nonzero option value, end_vel_nonzero unused.
// - limit switch handling stays active in this mode.
// - moves respect speed, acceleration, deceleration and jerk limits.
// - control and status processed once per 1 ms cycle.
// - profile type 3 enables jerk limit, 0 leaves it unlimited.
//
// Implementation choices: the register offsets and register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
`include "pps_params.svh"
module pps_seq
	import pps_pkg::*;
#(
	// application cycle length in clocks; a bench may shorten it to keep runs brief
	parameter int unsigned CYCLE_CLKS = `PPS_CYCLE_CLKS
)
(
	// clock and reset
	input  wire logic        ref_clk,
	input  wire logic        resetn,
	// wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	// drive side
	input  wire logic [31:0] actual_pos,
	input  wire logic [31:0] demand_pos,
	input  wire logic        at_speed,
	input  wire logic        closed_loop,
	input  wire logic        end_vel_nonzero,
	input  wire logic        limit_sw_ok,
	output logic      [31:0] goal_pos,
	output logic             goal_load,
	output logic             pass_through,
	output logic             halt_req,
	output logic             jerk_limit_en,
	output logic             limit_sw_en
);
	// ***********************************************
	// state
	// ***********************************************
	pps_regs_t r_ff;
	pps_regs_t nxt_r;
	logic      tick;
	logic      wr;
	logic      rd;
	logic [31:0] wmask;
	logic      in_mode;
	logic      start_edge;
	logic      halt_edge;
	logic [31:0] ref_base;
	logic [31:0] new_goal;
	logic      goal_ok;
	logic      arrived;
	logic [31:0] perr;
	logic [31:0] ferr;
	logic [31:0] statw;
	logic      ld;

	// ***********************************************
	// combinational helpers
	// ***********************************************
	always_comb
	begin
		tick       = (r_ff.tick_cnt == 18'(CYCLE_CLKS - 1));
		// write lands at the edge where the master sees ack, never earlier
		wr         = wb_cyc_i && wb_stb_i && wb_we_i && r_ff.ack_o;
		rd         = wb_cyc_i && wb_stb_i && !wb_we_i && !r_ff.ack_o;
		wmask      = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
		in_mode    = (r_ff.mode == `PPS_MODE_PP);
		start_edge = r_ff.ctrl[`PPS_CW_START] && !r_ff.ctrl_prev[`PPS_CW_START];
		halt_edge  = r_ff.ctrl[`PPS_CW_HALT] && !r_ff.ctrl_prev[`PPS_CW_HALT];
		// reference: 0 preceding goal, otherwise sampled actual position
		if (r_ff.opts[`PPS_OPT_REF_LSB +: 2] == 2'b00)
			ref_base = r_ff.prev_goal;
		else
			ref_base = r_ff.act_smp;
		if (r_ff.ctrl[`PPS_CW_REL])
			new_goal = ref_base + r_ff.target;
		else
			new_goal = r_ff.target;
		goal_ok    = ($signed(new_goal) >= $signed(r_ff.lim_lo)) &&
			($signed(new_goal) <= $signed(r_ff.lim_hi));
		perr       = actual_pos - r_ff.act_goal;
		if (perr[31])
			perr = -perr;
		ferr       = actual_pos - demand_pos;
		if (ferr[31])
			ferr = -ferr;
		arrived    = (perr <= r_ff.win);
		statw      = 32'h00000000;
		statw[`PPS_SW_REACHED] = r_ff.reached;
		statw[`PPS_SW_LIMIT]   = r_ff.limit;
		statw[`PPS_SW_ACK]     = r_ff.ack;
		statw[`PPS_SW_FOLERR]  = r_ff.folerr;
	end

	// ***********************************************
	// next state
	// ***********************************************
	always_comb
	begin
		nxt_r = r_ff;
		ld    = 1'b0;
		nxt_r.tick_cnt = tick ? 18'h00000 : r_ff.tick_cnt + 18'h00001;
		// bus slave, one wait state free: ack one cycle after request
		nxt_r.ack_o = wb_cyc_i && wb_stb_i && !r_ff.ack_o;
		if (wr)
		begin
			case (wb_adr_i)
				`PPS_OFF_CTRL:   nxt_r.ctrl   = (r_ff.ctrl & ~wmask[15:0]) | (wb_dat_i[15:0] & wmask[15:0]);
				`PPS_OFF_MODE:   nxt_r.mode   = wb_sel_i[0] ? wb_dat_i[7:0] : r_ff.mode;
				`PPS_OFF_TARGET: nxt_r.target = (r_ff.target & ~wmask) | (wb_dat_i & wmask);
				`PPS_OFF_OPTS:   nxt_r.opts   = wb_sel_i[0] ? wb_dat_i[7:0] : r_ff.opts;
				`PPS_OFF_LIMLO:  nxt_r.lim_lo = (r_ff.lim_lo & ~wmask) | (wb_dat_i & wmask);
				`PPS_OFF_LIMHI:  nxt_r.lim_hi = (r_ff.lim_hi & ~wmask) | (wb_dat_i & wmask);
				`PPS_OFF_WIN:    nxt_r.win    = (r_ff.win & ~wmask) | (wb_dat_i & wmask);
				`PPS_OFF_DWELL:  nxt_r.dwell  = (r_ff.dwell & ~wmask[15:0]) | (wb_dat_i[15:0] & wmask[15:0]);
				`PPS_OFF_FEWIN:  nxt_r.fe_win = (r_ff.fe_win & ~wmask) | (wb_dat_i & wmask);
				`PPS_OFF_FETMO:  nxt_r.fe_tmo = (r_ff.fe_tmo & ~wmask[15:0]) | (wb_dat_i[15:0] & wmask[15:0]);
				`PPS_OFF_PROF:   nxt_r.prof   = wb_sel_i[0] ? wb_dat_i[7:0] : r_ff.prof;
				default:         nxt_r.rdat   = r_ff.rdat;
			endcase
		end
		nxt_r.rdat = 32'h00000000;
		if (rd)
		begin
			case (wb_adr_i)
				`PPS_OFF_CTRL:   nxt_r.rdat = {16'h0000, r_ff.ctrl};
				`PPS_OFF_MODE:   nxt_r.rdat = {24'h000000, r_ff.mode};
				`PPS_OFF_TARGET: nxt_r.rdat = r_ff.target;
				`PPS_OFF_OPTS:   nxt_r.rdat = {24'h000000, r_ff.opts};
				`PPS_OFF_LIMLO:  nxt_r.rdat = r_ff.lim_lo;
				`PPS_OFF_LIMHI:  nxt_r.rdat = r_ff.lim_hi;
				`PPS_OFF_WIN:    nxt_r.rdat = r_ff.win;
				`PPS_OFF_DWELL:  nxt_r.rdat = {16'h0000, r_ff.dwell};
				`PPS_OFF_FEWIN:  nxt_r.rdat = r_ff.fe_win;
				`PPS_OFF_FETMO:  nxt_r.rdat = {16'h0000, r_ff.fe_tmo};
				`PPS_OFF_PROF:   nxt_r.rdat = {24'h000000, r_ff.prof};
				`PPS_OFF_STATUS: nxt_r.rdat = statw;
				`PPS_OFF_ACTPOS: nxt_r.rdat = r_ff.act_smp;
				`PPS_OFF_DEMPOS: nxt_r.rdat = demand_pos;
				`PPS_OFF_ACTIVE: nxt_r.rdat = r_ff.act_goal;
				`PPS_OFF_PEND:   nxt_r.rdat = {r_ff.pend_vld, 31'h00000000};
				`PPS_OFF_DRIVE:  nxt_r.rdat = {29'h00000000, limit_sw_ok, closed_loop, at_speed};
				default:         nxt_r.rdat = 32'h00000000;
			endcase
		end
		// application cycle: everything below runs once per ms
		if (tick)
		begin
			nxt_r.ctrl_prev = r_ff.ctrl;
			nxt_r.mode_prev = in_mode;
			nxt_r.act_smp   = actual_pos;
			nxt_r.limit     = ($signed(demand_pos) < $signed(r_ff.lim_lo)) ||
				($signed(demand_pos) > $signed(r_ff.lim_hi));
			if (closed_loop && (ferr > r_ff.fe_win))
			begin
				if (r_ff.fe_cnt >= r_ff.fe_tmo)
					nxt_r.folerr = 1'b1;
				else
					nxt_r.fe_cnt = r_ff.fe_cnt + 16'h0001;
			end
			else
			begin
				nxt_r.fe_cnt = 16'h0000;
				nxt_r.folerr = 1'b0;
			end
			// ack returns low with the start bit, except while a goal waits
			if (!r_ff.ctrl[`PPS_CW_START] && !r_ff.pend_vld)
				nxt_r.ack = 1'b0;
			if (in_mode && !r_ff.mode_prev)
			begin
				nxt_r.pend_vld = 1'b0;
				nxt_r.ack      = 1'b0;
				nxt_r.st       = PPS_IDLE;
			end
			else if (in_mode && start_edge && !r_ff.ack && goal_ok)
			begin
				nxt_r.ack = 1'b1;
				if (r_ff.opts[`PPS_OPT_CLR_LSB +: 2] != 2'b00)
					nxt_r.ctrl[`PPS_CW_START] = 1'b0;
				if (r_ff.st == PPS_IDLE || r_ff.ctrl[`PPS_CW_IMMED])
				begin
					nxt_r.act_goal  = new_goal;
					nxt_r.act_pass  = 1'b0;
					nxt_r.prev_goal = new_goal;
					nxt_r.reached   = 1'b0;
					nxt_r.dwell_cnt = 16'h0000;
					nxt_r.pend_vld  = 1'b0;
					nxt_r.st        = PPS_MOVE;
					ld              = 1'b1;
				end
				else if (!r_ff.pend_vld)
				begin
					nxt_r.pend_vld  = 1'b1;
					nxt_r.pend_goal = new_goal;
					nxt_r.pend_pass = r_ff.ctrl[`PPS_CW_PASS] && at_speed;
					nxt_r.prev_goal = new_goal;
				end
			end
			// trade-off: with pass-through the buffered goal is taken on arrival, no dwell
			case (r_ff.st)
				PPS_IDLE:
				begin
					// leaving idle is done by the start path above
				end
				PPS_MOVE:
				begin
					if (halt_edge || r_ff.ctrl[`PPS_CW_HALT])
						nxt_r.st = PPS_HALT;
					else if (!ld && arrived && r_ff.pend_vld && r_ff.pend_pass)
					begin
						nxt_r.act_goal = r_ff.pend_goal;
						nxt_r.pend_vld = 1'b0;
						ld             = 1'b1;
					end
					else if (!ld && arrived)
					begin
						if (r_ff.dwell_cnt >= r_ff.dwell)
						begin
							if (r_ff.pend_vld)
							begin
								nxt_r.act_goal  = r_ff.pend_goal;
								nxt_r.pend_vld  = 1'b0;
								nxt_r.dwell_cnt = 16'h0000;
								ld              = 1'b1;
							end
							else
							begin
								nxt_r.reached = 1'b1;
								nxt_r.st      = PPS_IDLE;
							end
						end
						else
							nxt_r.dwell_cnt = r_ff.dwell_cnt + 16'h0001;
					end
					else
						nxt_r.dwell_cnt = 16'h0000;
				end
				PPS_HALT:
				begin
					if (!r_ff.ctrl[`PPS_CW_HALT])
						nxt_r.st = PPS_MOVE;
				end
				default:
				begin
					nxt_r.st = PPS_IDLE;
				end
			endcase
			nxt_r.act_pass = (nxt_r.pend_vld && nxt_r.pend_pass);
		end
	end

	// ***********************************************
	// registers
	// ***********************************************
	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			r_ff        <= '0;
			r_ff.st     <= PPS_IDLE;
			r_ff.lim_lo <= `PPS_RST_LIMLO;
			r_ff.lim_hi <= `PPS_RST_LIMHI;
			r_ff.win    <= `PPS_RST_WIN;
			r_ff.dwell  <= `PPS_RST_DWELL;
			r_ff.fe_win <= `PPS_RST_FEWIN;
			r_ff.fe_tmo <= `PPS_RST_FETMO;
		end
		else
			r_ff <= nxt_r;
	end

	// ***********************************************
	// outputs
	// ***********************************************
	logic load_ff;
	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
			load_ff <= 1'b0;
		else
			load_ff <= ld;
	end
	assign wb_dat_o      = r_ff.rdat;
	assign wb_ack_o      = r_ff.ack_o;
	assign goal_pos      = r_ff.act_goal;
	assign goal_load     = load_ff;
	assign pass_through  = r_ff.act_pass;
	assign halt_req      = (r_ff.st == PPS_HALT);
	assign jerk_limit_en = (r_ff.prof == `PPS_PROF_JERK);
	assign limit_sw_en   = in_mode;

	// ***********************************************
	// checks
	// ***********************************************
	chk_ack_needs_edge: assert property (@(posedge ref_clk) disable iff (!resetn)
		$rose(r_ff.ack) |-> $past(start_edge) && $past(tick))
		else $error("ack rose without start edge");
	chk_ack_no_bad: assert property (@(posedge ref_clk) disable iff (!resetn)
		(tick && start_edge && !goal_ok && !r_ff.ack) |=> !r_ff.ack)
		else $error("ack given for invalid goal");
	chk_reached_dwell: assert property (@(posedge ref_clk) disable iff (!resetn)
		$rose(r_ff.reached) |-> !r_ff.pend_vld && $past(arrived))
		else $error("reached without arrival");
	chk_immed_load: assert property (@(posedge ref_clk) disable iff (!resetn)
		(tick && in_mode && r_ff.mode_prev && start_edge && !r_ff.ack && goal_ok &&
		r_ff.ctrl[`PPS_CW_IMMED]) |=> (r_ff.act_goal == $past(new_goal)) && goal_load)
		else $error("immediate goal not applied");
	chk_buf_full: assert property (@(posedge ref_clk) disable iff (!resetn)
		(tick && r_ff.pend_vld && !r_ff.ctrl[`PPS_CW_IMMED] && r_ff.st == PPS_MOVE && !arrived)
		|=> r_ff.pend_goal == $past(r_ff.pend_goal))
		else $error("full buffer overwritten");
	chk_halt_state: assert property (@(posedge ref_clk) disable iff (!resetn)
		(tick && r_ff.st == PPS_MOVE && r_ff.ctrl[`PPS_CW_HALT]) |=> halt_req)
		else $error("halt not taken");
	chk_mode_flush: assert property (@(posedge ref_clk) disable iff (!resetn)
		(tick && in_mode && !r_ff.mode_prev) |=> !r_ff.ack && !r_ff.pend_vld)
		else $error("mode entry did not flush");
	chk_folerr_loop: assert property (@(posedge ref_clk) disable iff (!resetn)
		(tick && !closed_loop) |=> !r_ff.folerr)
		else $error("following error in open loop");
	chk_tick_only: assert property (@(posedge ref_clk) disable iff (!resetn)
		!$past(tick) |-> $stable(r_ff.ack) && $stable(r_ff.st))
		else $error("state changed off cycle");
	cov_buffered: cover property (@(posedge ref_clk) disable iff (!resetn) $rose(r_ff.pend_vld));
	cov_reached: cover property (@(posedge ref_clk) disable iff (!resetn) $rose(r_ff.reached));
	cov_halt: cover property (@(posedge ref_clk) disable iff (!resetn) $rose(halt_req));
	cov_pass: cover property (@(posedge ref_clk) disable iff (!resetn) $rose(pass_through));
endmodule
`default_nettype wire

//--- profile_position_sequencer_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "pps_params.svh"
module profile_position_sequencer_tb;
	// shortened application cycle so ten motion ticks fit a short run
	localparam int CYC = 2000;
	localparam int TMO = 11 * CYC;
	localparam logic [7:0] RA [8] = '{`PPS_OFF_LIMLO, `PPS_OFF_LIMHI, `PPS_OFF_WIN, `PPS_OFF_DWELL,
		`PPS_OFF_FEWIN, `PPS_OFF_FETMO, `PPS_OFF_STATUS, 8'h44};
	localparam logic [31:0] RV [8] = '{32'h80000000, 32'h7FFFFFFF, 32'h0000000A, 32'h00000000,
		32'h00000100, 32'h0000000A, 32'h00000000, 32'h00000000};
	logic        ref_clk = 1'b0;
	logic        resetn;
	logic [31:0] actual_pos;
	logic [31:0] demand_pos;
	logic        at_speed;
	logic        closed_loop;
	logic        end_vel_nonzero;
	logic        limit_sw_ok;
	logic        wb_cyc;
	logic        wb_stb;
	logic        wb_we;
	logic        wb_ack;
	logic [7:0]  wb_adr;
	logic [3:0]  wb_sel;
	logic [31:0] wb_wdat;
	logic [31:0] wb_rdat;
	logic [31:0] goal_pos;
	logic        goal_load;
	logic        pass_through;
	logic        halt_req;
	logic        jerk_limit_en;
	logic        limit_sw_en;
	int          num_errors = 0;
	int          samples_checked = 0;
	int          seed = 55;
	int          cyc_cnt = 0;
	int          loads = 0;
	logic [31:0] rd;
	logic [31:0] t1;
	logic [31:0] t3;
	logic [31:0] dl;
	// ****************************************
	// instances
	// ****************************************
	pps_seq #(.CYCLE_CLKS(CYC)) pps_seq_inst (.ref_clk(ref_clk), .resetn(resetn), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
		.wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat),
		.wb_ack_o(wb_ack), .actual_pos(actual_pos), .demand_pos(demand_pos), .at_speed(at_speed),
		.closed_loop(closed_loop), .end_vel_nonzero(end_vel_nonzero), .limit_sw_ok(limit_sw_ok),
		.goal_pos(goal_pos), .goal_load(goal_load), .pass_through(pass_through), .halt_req(halt_req),
		.jerk_limit_en(jerk_limit_en), .limit_sw_en(limit_sw_en));
	pps_host pps_host_inst (.ref_clk(ref_clk), .wb_cyc_o(wb_cyc), .wb_stb_o(wb_stb), .wb_we_o(wb_we),
		.wb_adr_o(wb_adr), .wb_sel_o(wb_sel), .wb_dat_o(wb_wdat), .wb_dat_i(wb_rdat), .wb_ack_i(wb_ack));
	// ****************************************
	// helpers
	// ****************************************
	always #2.5 ref_clk = ~ref_clk;
	always @(posedge ref_clk)
	begin
		cyc_cnt <= resetn ? cyc_cnt + 1 : 0;
		if (goal_load)
			loads <= loads + 1;
		if (cyc_cnt == TMO)
		begin
			num_errors++;
			finish_test();
		end
	end
	function automatic logic [31:0] rand_goal();
		return 32'h00001000 + ($random(seed) & 32'h00FFFFFF);
	endfunction
	function automatic logic [31:0] rel_goal(input logic [31:0] base, input logic [31:0] d);
		return base + d;
	endfunction
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		pps_host_inst.xfer(1'b1, a, d, q);
	endtask
	task automatic rdr(input logic [7:0] a);
		pps_host_inst.xfer(1'b0, a, 32'h0, rd);
	endtask
	task automatic cmp32(input string nm, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e)
		begin
			num_errors++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic cmp1(input string nm, input logic e, input logic g);
		samples_checked++;
		if (g !== e)
		begin
			num_errors++;
			$display("Error %s expected %b seen %b", nm, e, g);
		end
	endtask
	// middle of a motion cycle: far from the tick, whatever its exact phase
	task automatic mid(input int k);
		while (cyc_cnt < k * CYC + CYC / 2)
			@(posedge ref_clk);
		end_vel_nonzero <= $random(seed);
		limit_sw_ok <= $random(seed);
	endtask
	task automatic finish_test();
		num_errors += pps_host_inst.timeouts;
		$display("checked %0d mismatches %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// ****************************************
	// main sequence
	// ****************************************
	initial
	begin
		resetn = 1'b0;
		actual_pos = 32'h0;
		demand_pos = 32'h00000100;
		at_speed = 1'b1;
		closed_loop = 1'b0;
		end_vel_nonzero = 1'b0;
		limit_sw_ok = 1'b1;
		repeat (6) @(posedge ref_clk);
		resetn <= 1'b1;
		@(posedge ref_clk);
		for (int i = 0; i < 8; i++)
		begin
			rdr(RA[i]);
			cmp32("reset value", RV[i], rd);
		end
		wr(8'h44, 32'hFFFFFFFF);
		rdr(8'h44);
		cmp32("unmapped", 32'h0, rd);
		$display("test registers done");
		// limits chosen so the check reads the same signed or unsigned
		wr(`PPS_OFF_LIMLO, 32'h0);
		wr(`PPS_OFF_PROF, 32'h3);
		wr(`PPS_OFF_MODE, 32'h1);
		mid(1);
		cmp1("limit_sw_en", 1'b1, limit_sw_en);
		cmp1("jerk_limit_en", 1'b1, jerk_limit_en);
		t1 = rand_goal();
		wr(`PPS_OFF_TARGET, t1);
		wr(`PPS_OFF_CTRL, 32'h30);
		mid(2);
		cmp32("goal_pos", t1, goal_pos);
		rdr(`PPS_OFF_STATUS);
		cmp1("ack", 1'b1, rd[`PPS_SW_ACK]);
		wr(`PPS_OFF_TARGET, rand_goal());
		wr(`PPS_OFF_CTRL, 32'h30);
		mid(3);
		cmp32("goal_pos", t1, goal_pos);
		wr(`PPS_OFF_CTRL, 32'h20);
		mid(4);
		rdr(`PPS_OFF_STATUS);
		cmp1("ack", 1'b0, rd[`PPS_SW_ACK]);
		$display("test start edge done");
		dl = $random(seed) & 32'h00000FFF;
		wr(`PPS_OFF_TARGET, dl);
		wr(`PPS_OFF_CTRL, 32'h70);
		mid(5);
		cmp32("goal_pos", rel_goal(t1, dl), goal_pos);
		wr(`PPS_OFF_CTRL, 32'h20);
		$display("test relative done");
		mid(6);
		t3 = rand_goal();
		wr(`PPS_OFF_TARGET, t3);
		wr(`PPS_OFF_CTRL, 32'h10);
		mid(7);
		rdr(`PPS_OFF_PEND);
		cmp1("pending", 1'b1, rd[31]);
		cmp32("goal_pos", rel_goal(t1, dl), goal_pos);
		cmp1("pass_through", 1'b0, pass_through);
		actual_pos <= rel_goal(t1, dl);
		wr(`PPS_OFF_CTRL, 32'h0);
		mid(9);
		cmp32("goal_pos", t3, goal_pos);
		$display("test buffered done");
		wr(`PPS_OFF_CTRL, 32'h100);
		wr(`PPS_OFF_LIMHI, 32'h10);
		demand_pos <= 32'h20;
		mid(10);
		cmp1("halt_req", 1'b1, halt_req);
		rdr(`PPS_OFF_STATUS);
		cmp1("limit", 1'b1, rd[`PPS_SW_LIMIT]);
		cmp32("goal loads", 32'h00000003, loads);
		$display("test halt and limit done");
		finish_test();
	end
endmodule
`default_nettype wire
